// ---- src/two_wire_control_slave.sv ----
// Two-wire serial slave, control register bank and pixel output port steering.
// Assumes scl and sda come from pins with external pull-ups and a pixel clock
// that is unrelated to mclk; the pad logic merges sda_oe_n with the pull-up.
//
// Summary of operation
// R1: Five-bit phase, 32 steps of 11.25, default 16.
// R2: Two-bit oscillator band decode, default 01.
// R3: Three-bit loop drive, 50 to 1500 uA.
// R4: Dual port: first, odd samples to A.
// R5: Swap bit ignored in single-port mode.
// R6: Swap written at bit 4, read at 7.
// R7: Die revision readable at bits 3 to 1.
// R8: Address 10011 plus two select pins.
// R9: First byte is address then direction bit.
// R10: Acknowledge on match, silent on mismatch.
// R11: Data changes only while clock low.
// R12: Start and stop detected with clock high.
// R13: Bytes shifted most significant bit first.
// R14: Refused write byte leaves data line released.
// R15: Master not acknowledging ends the read.
// R16: Pointer byte then data, auto-increment.
// R17: Burst write pointer stops at 0Eh.
// R18: Pointer above 0Eh is not acknowledged.
// R19: Read starts at pointer, increments each byte.
// R20: Repeated start keeps the pointer.
// R21: Split clear sends all pixels to A.
// R22: Acknowledge valid writes and apply fields.
// R23: Fields hold defaults before any access.
`timescale 1ns/1ns

module two_wire_control_slave
  import ctl_port_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        scl,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n,
  input  wire logic [1:0]  bus_address_select_pins,
  output clk_setup_s       clk_setup,
  output clk_decode_s      clk_decode,
  input  wire logic        pix_clk,
  input  wire logic        line_sync,
  input  wire logic [7:0]  pix_data,
  output logic [7:0]       port_a,
  output logic [7:0]       port_b,
  output logic             port_b_oe_n
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic       scl_m, scl_s, scl_p;
  logic       sda_m, sda_s, sda_p;
  logic [1:0] sel_m, sel_s;

  // Three stages for scl and sda, two for the select pins; the second and third stages feed the edge logic.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_p <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_p <= 1'b1;
      sel_m <= 2'h0;
      sel_s <= 2'h0;
    end else begin
      scl_m <= scl;
      scl_s <= scl_m;
      scl_p <= scl_s;
      sda_m <= sda_in;
      sda_s <= sda_m;
      sda_p <= sda_s;
      sel_m <= bus_address_select_pins;
      sel_s <= sel_m;
    end
  end

  // ****************************************************************
  // Bus events
  // ****************************************************************
  logic scl_rise, scl_fall, start_ev, stop_ev;

  // Any data edge while the clock stays high is a framing event.
  assign scl_rise = scl_s & ~scl_p;
  assign scl_fall = ~scl_s & scl_p;
  assign start_ev = scl_s & scl_p & sda_p & ~sda_s;  // R12
  assign stop_ev  = scl_s & scl_p & ~sda_p & sda_s;  // R12

  // ****************************************************************
  // Register bank and read data
  // ****************************************************************
  logic [7:0] regs_q [REG_COUNT];
  logic       swap_q;
  bus_state_e state_q, next_q;
  logic [3:0] bitcnt_q;
  logic [7:0] shift_q, tx_q, ptr_q;
  logic       drive_q;

  // Offset 0D reads back swap at the top and the die revision in the middle.
  function automatic logic [7:0] read_reg(input logic [7:0] idx);
    logic [7:0] v;
    v = 8'h00;
    if (idx == OFS_ORDER_REV) begin
      v[SWAP_RD_BIT]          = swap_q;        // R6
      v[REV_LSB +: 3]         = DIE_REVISION;  // R7
    end else if (idx <= PTR_MAX) begin
      v = regs_q[idx[3:0]];
    end
    return v;
  endfunction : read_reg

  logic       byte_done, addr_match, wr_en;
  logic [7:0] ptr_inc;

  assign byte_done  = scl_fall && (bitcnt_q == 4'd8);
  assign addr_match = (shift_q[7:3] == SLAVE_ADDR_HI) && (shift_q[2:1] == sel_s);  // R8
  assign wr_en      = (state_q == ST_WDATA) && byte_done;
  assign ptr_inc    = (ptr_q == PTR_MAX) ? PTR_MAX : ptr_q + 8'h01;  // R17

  logic [7:0] rd_byte;

  // Byte at the pointer; a process, not an assign, so it follows every bank write.
  always_comb begin
    rd_byte = read_reg(ptr_q);
  end

  // Bytes land in the bank when their eighth bit is in; 0D keeps only the swap bit.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_q[i] <= REG_DEFAULTS[i];  // R23
      end
      swap_q <= 1'b0;
    end else if (wr_en) begin
      if (ptr_q == OFS_ORDER_REV) begin
        swap_q <= shift_q[SWAP_WR_BIT];  // R6
      end else begin
        regs_q[ptr_q[3:0]] <= shift_q;  // R22
      end
    end
  end

  // ****************************************************************
  // Serial protocol engine
  // ****************************************************************
  // Apart from the release on a start or stop, every drive change happens on a seen
  // falling clock edge, so the master never sees data move while the clock is high.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q  <= ST_IDLE;
      next_q   <= ST_IDLE;
      bitcnt_q <= 4'h0;
      shift_q  <= 8'h00;
      tx_q     <= 8'h00;
      ptr_q    <= 8'h00;
      drive_q  <= 1'b0;
    end else if (start_ev) begin
      state_q  <= ST_ADDR;  // R20
      bitcnt_q <= 4'h0;
      drive_q  <= 1'b0;
    end else if (stop_ev) begin
      state_q <= ST_IDLE;
      drive_q <= 1'b0;
    end else begin
      case (state_q)
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (scl_rise) begin
            shift_q  <= {shift_q[6:0], sda_s};  // R13
            bitcnt_q <= bitcnt_q + 4'h1;
          end else if (byte_done) begin
            if (state_q == ST_ADDR) begin
              if (addr_match) begin
                drive_q <= 1'b1;  // R10
                state_q <= ST_ACK;
                next_q  <= shift_q[0] ? ST_RDATA : ST_PTR;  // R9
                tx_q    <= read_reg(ptr_q);  // R19
              end else begin
                state_q <= ST_WAIT;  // R10
              end
            end else if (state_q == ST_PTR) begin
              if (shift_q <= PTR_MAX) begin
                ptr_q   <= shift_q;  // R16
                drive_q <= 1'b1;
                state_q <= ST_ACK;
                next_q  <= ST_WDATA;
              end else begin
                state_q <= ST_WAIT;  // R18
              end
            end else begin
              ptr_q   <= ptr_inc;  // R16
              drive_q <= 1'b1;  // R22
              state_q <= ST_ACK;
              next_q  <= ST_WDATA;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bitcnt_q <= 4'h0;
            state_q  <= next_q;
            drive_q  <= (next_q == ST_RDATA) ? ~tx_q[7] : 1'b0;  // R13
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            bitcnt_q <= bitcnt_q + 4'h1;
          end else if (byte_done) begin
            drive_q <= 1'b0;
            state_q <= ST_RACK;
          end else if (scl_fall) begin
            tx_q    <= {tx_q[6:0], 1'b0};
            drive_q <= ~tx_q[6];
          end
        end
        ST_RACK: begin
          if (scl_rise) begin
            ptr_q <= ptr_inc;  // R19
            if (sda_s) begin
              state_q <= ST_WAIT;  // R15
            end
          end else if (scl_fall) begin
            tx_q     <= rd_byte;
            drive_q  <= ~rd_byte[7];
            bitcnt_q <= 4'h0;
            state_q  <= ST_RDATA;
          end
        end
        ST_WAIT: begin
          drive_q <= 1'b0;  // R14
        end
        default: begin
          state_q <= ST_IDLE;
          drive_q <= 1'b0;
        end
      endcase
    end
  end

  // Open-drain pad: the enable is low only while pulling the line low.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sda_out  <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      sda_out  <= 1'b0;
      sda_oe_n <= ~drive_q;  // R11
    end
  end

  // ****************************************************************
  // Clock generator fields and their decode
  // ****************************************************************
  logic [4:0] phase_f;
  logic [1:0] band_f;
  logic [2:0] drive_f;

  assign phase_f = regs_q[OFS_CLOCK_SETUP[3:0]][PHASE_LSB +: 5];
  assign band_f  = regs_q[OFS_CLOCK_RANGE[3:0]][BAND_LSB +: 2];
  assign drive_f = regs_q[OFS_CLOCK_RANGE[3:0]][DRIVE_LSB +: 3];

  // Registered copies so the analog controls see no decode glitches.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      clk_setup.sample_phase    <= REG_DEFAULTS[OFS_CLOCK_SETUP[3:0]][PHASE_LSB +: 5];  // R23
      clk_setup.oscillator_band <= REG_DEFAULTS[OFS_CLOCK_RANGE[3:0]][BAND_LSB +: 2];  // R23
      clk_setup.filter_drive    <= REG_DEFAULTS[OFS_CLOCK_RANGE[3:0]][DRIVE_LSB +: 3];  // R23
      clk_decode <= '0;
    end else begin
      clk_setup.sample_phase    <= phase_f;  // R1
      clk_setup.oscillator_band <= band_f;  // R2
      clk_setup.filter_drive    <= drive_f;  // R3
      clk_decode.phase_cdeg     <= 16'({11'h000, phase_f} * PHASE_STEP_CDEG);  // R1
      clk_decode.band_lo_mhz    <= BAND_LO_MHZ[band_f];  // R2
      clk_decode.band_hi_mhz    <= BAND_HI_MHZ[band_f];  // R2
      clk_decode.drive_ua       <= DRIVE_UA[drive_f];  // R3
    end
  end

  // ****************************************************************
  // Pixel side, on pix_clk
  // ****************************************************************
  logic split_m, split_s, swap_m, swap_s;
  logic line_p, odd_q, lead, odd_d, to_a;

  // The mode bits are quasi-static levels, so two stages are enough here.
  always_ff @(posedge pix_clk or negedge resetn) begin
    if (!resetn) begin
      split_m <= 1'b1;
      split_s <= 1'b1;
      swap_m  <= 1'b0;
      swap_s  <= 1'b0;
    end else begin
      split_m <= regs_q[OFS_OUTPUT_CTRL[3:0]][SPLIT_BIT];
      split_s <= split_m;
      swap_m  <= swap_q;
      swap_s  <= swap_m;
    end
  end

  assign lead  = line_sync & ~line_p;
  assign odd_d = lead ? 1'b1 : ~odd_q;  // R4
  assign to_a  = ~split_s | (odd_d ^ swap_s);  // R5 R21

  // In dual-port mode samples alternate between the ports; port B floats in single-port mode.
  always_ff @(posedge pix_clk or negedge resetn) begin
    if (!resetn) begin
      line_p      <= 1'b0;
      odd_q       <= 1'b0;
      port_a      <= 8'h00;
      port_b      <= 8'h00;
      port_b_oe_n <= 1'b0;
    end else begin
      line_p      <= line_sync;
      odd_q       <= odd_d;
      port_b_oe_n <= ~split_s;  // R21
      if (to_a) begin
        port_a <= pix_data;  // R4
      end else begin
        port_b <= pix_data;  // R4
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_addr_done;
    state_q == ST_ADDR && byte_done;
  endsequence

  sequence s_ptr_done;
    state_q == ST_PTR && byte_done;
  endsequence

  sequence s_wdata_done;
    state_q == ST_WDATA && byte_done;
  endsequence

  a_addr_ack: assert property (@(posedge mclk) disable iff (!resetn)  // R10
    s_addr_done ##0 addr_match |=> drive_q ##1 !sda_oe_n)
    else $error("matching address not acknowledged");

  a_addr_silent: assert property (@(posedge mclk) disable iff (!resetn)  // R10
    s_addr_done ##0 !addr_match |=> state_q == ST_WAIT ##1 sda_oe_n)
    else $error("mismatched address drove the data line");

  a_ptr_refuse: assert property (@(posedge mclk) disable iff (!resetn)  // R18
    s_ptr_done ##0 (shift_q > PTR_MAX) |=> !drive_q && ptr_q == $past(ptr_q))
    else $error("pointer above limit was accepted");

  a_ptr_clamp: assert property (@(posedge mclk) disable iff (!resetn)  // R17
    s_wdata_done ##0 (ptr_q == PTR_MAX) |=> ptr_q == PTR_MAX)
    else $error("pointer moved past last register");

  a_write_store: assert property (@(posedge mclk) disable iff (!resetn)  // R22
    s_wdata_done ##0 (ptr_q == OFS_CLOCK_SETUP) |=> ##1
      clk_setup.sample_phase == $past(shift_q[PHASE_LSB +: 5], 2))
    else $error("written phase did not reach the clock setup");

  a_read_nack: assert property (@(posedge mclk) disable iff (!resetn)  // R15
    state_q == ST_RACK && scl_rise && sda_s && !start_ev && !stop_ev
      |=> !drive_q ##1 sda_oe_n)
    else $error("data line held after master refused");

  a_start_frame: assert property (@(posedge mclk) disable iff (!resetn)  // R12
    start_ev |=> state_q == ST_ADDR && bitcnt_q == 4'h0 && !drive_q)
    else $error("start did not reopen the address phase");

  a_drive_scl_low: assert property (@(posedge mclk) disable iff (!resetn)  // R11
    $changed(drive_q) |-> !scl_s || $past(start_ev) || $past(stop_ev))
    else $error("data line changed while clock high");

  a_swap_readback: assert property (@(posedge mclk) disable iff (!resetn)  // R6
    read_reg(OFS_ORDER_REV) == {swap_q, 3'h0, DIE_REVISION, 1'b0})
    else $error("order register readback wrong");

  a_single_port: assert property (@(posedge pix_clk) disable iff (!resetn)  // R5
    !split_s |=> port_b_oe_n && port_a == $past(pix_data))
    else $error("single port did not route to port A");

  a_first_pixel: assert property (@(posedge pix_clk) disable iff (!resetn)  // R4
    lead && split_s && !swap_s |=> port_a == $past(pix_data) ##1
      port_b == $past(pix_data))
    else $error("first pixel after line sync misrouted");

endmodule : two_wire_control_slave

// ---- src/ctl_port_pkg.sv ----
// Shared constants and types for the two-wire control slave and its register bank.
// Assumes a single-clock control side and a separate pixel-clock side.
package ctl_port_pkg;

  // ****************************************************************
  // Bus address and register map
  // ****************************************************************
  localparam logic [4:0] SLAVE_ADDR_HI     = 5'h13;  // Fixed upper five address bits, 10011.
  localparam logic [7:0] PTR_MAX           = 8'h0e;
  localparam int         REG_COUNT         = 15;
  localparam logic [7:0] OFS_OUTPUT_CTRL   = 8'h0a;
  localparam logic [7:0] OFS_CLOCK_SETUP   = 8'h0b;  // clock_generator_setup.
  localparam logic [7:0] OFS_CLOCK_RANGE   = 8'h0c;
  localparam logic [7:0] OFS_ORDER_REV     = 8'h0d;  // output_order_and_revision.

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int PHASE_LSB      = 3;
  localparam int BAND_LSB       = 6;
  localparam int DRIVE_LSB      = 3;
  localparam int SPLIT_BIT      = 7;
  localparam int SWAP_WR_BIT    = 4;
  localparam int SWAP_RD_BIT    = 7;
  localparam int REV_LSB        = 1;

  // Arbitrary neutral die revision value.
  localparam logic [2:0] DIE_REVISION = 3'h1;

  // ****************************************************************
  // Power-up values, one per register index 00 to 0E
  // ****************************************************************
  localparam logic [7:0] REG_DEFAULTS [REG_COUNT] = '{
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80, 8'h80, 8'h80,
    8'h80, 8'h80, 8'hf4, 8'h80, 8'h48, 8'h00, 8'h00};

  // ****************************************************************
  // Decode tables for clock generator fields
  // ****************************************************************
  localparam logic [15:0] PHASE_STEP_CDEG = 16'd1125;  // 11.25 degrees per step.
  localparam logic [7:0]  BAND_LO_MHZ [4] = '{8'd20, 8'd50, 8'd80, 8'd110};
  localparam logic [7:0]  BAND_HI_MHZ [4] = '{8'd60, 8'd90, 8'd120, 8'd140};
  localparam logic [10:0] DRIVE_UA [8]    = '{11'd50, 11'd100, 11'd150, 11'd250,
                                              11'd350, 11'd500, 11'd750, 11'd1500};

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_PTR, ST_WDATA, ST_RDATA, ST_RACK, ST_ACK, ST_WAIT
  } bus_state_e;

  typedef struct packed {
    logic [4:0] sample_phase;
    logic [1:0] oscillator_band;
    logic [2:0] filter_drive;
  } clk_setup_s;

  typedef struct packed {
    logic [15:0] phase_cdeg;
    logic [7:0]  band_lo_mhz;
    logic [7:0]  band_hi_mhz;
    logic [10:0] drive_ua;
  } clk_decode_s;

endpackage : ctl_port_pkg

// ---- sim/two_wire_master.sv ----
// Behavioural two-wire bus master that drives the control slave's serial pins.
// Assumes a pull-up on the data line; the bench merges both drivers into one wire.
`timescale 1ns/1ns

module two_wire_master (
  input  wire logic mclk,
  input  wire logic sda_wire,
  output logic      scl,
  output logic      sda_pull
);
  // Extra low-phase cycles; a non-zero value plays a slow master.
  int lag = 0;

  // The bus idles with the clock high and the data line released.
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  // Data moves three cycles after the clock falls, one cycle before the slave's pad reacts to that fall.
  task automatic bit_io(input logic tx, output logic rx);
    tick(3);
    sda_pull <= ~tx;
    tick(7 + lag);
    scl <= 1'b1;
    tick(5);
    rx = sda_wire;
    tick(5);
    scl <= 1'b0;
  endtask : bit_io

  // Works from idle and as a repeated start with the clock low.
  task automatic start_cond();
    tick(3);
    sda_pull <= 1'b0;
    tick(7);
    scl <= 1'b1;
    tick(5);
    sda_pull <= 1'b1;
    tick(5);
    scl <= 1'b0;
  endtask : start_cond

  task automatic stop_cond();
    tick(3);
    sda_pull <= 1'b1;
    tick(7);
    scl <= 1'b1;
    tick(5);
    sda_pull <= 1'b0;
    tick(10);
  endtask : stop_cond

  // Eight bits then the ninth; a ninth of 1 releases the line for the answer.
  task automatic byte_io(input logic [7:0] tx, input logic ninth,
                         output logic [7:0] rx, output logic acked);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], s);
      rx[i] = s;
    end
    bit_io(ninth, s);
    acked = (s === 1'b0);
  endtask : byte_io

endmodule : two_wire_master

// ---- sim/tb_two_wire_control_slave.sv ----
// Self-checking bench for the two-wire control slave and its pixel port steering.
// Assumes the master model in two_wire_master.sv and the design package.
`timescale 1ns/1ns

`define CHECK_EQ(got, exp) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    bad_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end

module tb_two_wire_control_slave
  import ctl_port_pkg::*;
;
  logic        mclk, resetn, pix_clk, line_sync, scl, sda_pull, sda_out, sda_oe_n;
  logic        port_b_oe_n;
  logic [7:0]  pix_data, port_a, port_b;
  logic [1:0]  sel_pins;
  logic [31:0] seed = 32'd33615;
  clk_setup_s  clk_setup, cs;
  clk_decode_s clk_decode;
  wire         sda_wire;
  int          bad_count, cmp_count, cycles;

  // Pointer values just past the top and at the far end of the range.
  logic [7:0] d_bad [2] = '{8'h0f, 8'hff};

  // Open-drain wire with pull-up: low if either party pulls.
  assign sda_wire = (sda_pull || (!sda_oe_n && !sda_out)) ? 1'b0 : 1'b1;

  two_wire_control_slave two_wire_control_slave_i (
    .mclk(mclk), .resetn(resetn), .scl(scl), .sda_in(sda_wire), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .bus_address_select_pins(sel_pins), .clk_setup(clk_setup),
    .clk_decode(clk_decode), .pix_clk(pix_clk), .line_sync(line_sync),
    .pix_data(pix_data), .port_a(port_a), .port_b(port_b), .port_b_oe_n(port_b_oe_n));

  two_wire_master two_wire_master_i (
    .mclk(mclk), .sda_wire(sda_wire), .scl(scl), .sda_pull(sda_pull));

  // ****************************************************************
  // Clocks, timeout and helpers
  // ****************************************************************
  always #10 mclk = ~mclk;

  // The pixel clock is 125 ns and deliberately out of phase with mclk.
  always begin
    #63 pix_clk = ~pix_clk;
    #62 pix_clk = ~pix_clk;
  end

  // A hang costs one mismatch and ends the run.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      give_verdict();
    end
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  function automatic clk_decode_s exp_decode(input clk_setup_s c);
    clk_decode_s e;
    e.phase_cdeg  = 16'(c.sample_phase) * PHASE_STEP_CDEG;
    e.band_lo_mhz = BAND_LO_MHZ[c.oscillator_band];
    e.band_hi_mhz = BAND_HI_MHZ[c.oscillator_band];
    e.drive_ua    = DRIVE_UA[c.filter_drive];
    return e;
  endfunction : exp_decode

  task automatic send_addr(input logic [1:0] sel, input logic rd, input logic exp_ack);
    logic [7:0] rx;
    logic       ack;
    two_wire_master_i.start_cond();
    two_wire_master_i.byte_io({SLAVE_ADDR_HI, sel, rd}, 1'b1, rx, ack);
    `CHECK_EQ(ack, exp_ack);
  endtask : send_addr

  task automatic send_byte(input logic [7:0] b, input logic exp_ack);
    logic [7:0] rx;
    logic       ack;
    two_wire_master_i.byte_io(b, 1'b1, rx, ack);
    `CHECK_EQ(ack, exp_ack);
  endtask : send_byte

  task automatic write_regs(input logic [7:0] ptr, input logic [7:0] d [4], input int n);
    send_addr(sel_pins, 1'b0, 1'b1);
    send_byte(ptr, 1'b1);
    for (int i = 0; i < n; i++) send_byte(d[i], 1'b1);
    two_wire_master_i.stop_cond();
  endtask : write_regs

  // Pointer set by a write, then a repeated start turns the bus round.
  task automatic read_regs(input logic [7:0] ptr, input logic [7:0] exp [4], input int n);
    logic [7:0] rx;
    logic       ack;
    send_addr(sel_pins, 1'b0, 1'b1);
    send_byte(ptr, 1'b1);
    send_addr(sel_pins, 1'b1, 1'b1);
    for (int i = 0; i < n; i++) begin
      two_wire_master_i.byte_io(8'hff, 1'(i == n - 1), rx, ack);
      `CHECK_EQ(rx, exp[i]);
    end
    two_wire_master_i.tick(8);
    `CHECK_EQ(sda_oe_n, 1'b1);
    two_wire_master_i.stop_cond();
  endtask : read_regs

  // Nine samples after a line sync; each is checked at the falling edge after
  // the rising edge that latched it, so the port has settled.
  task automatic pix_line(input logic dual, input logic swap);
    logic [7:0] d [12];
    logic       to_a;
    write_regs(OFS_OUTPUT_CTRL, '{{dual, 7'h74}, 8'h00, 8'h00, 8'h00}, 1);
    write_regs(OFS_ORDER_REV, '{{3'h0, swap, 4'h0}, 8'h00, 8'h00, 8'h00}, 1);
    two_wire_master_i.tick(40);
    for (int k = 0; k <= 9; k++) begin
      @(posedge pix_clk);
      seed = xs(seed);
      d[k+1] = seed[7:0];
      line_sync <= (k == 0);
      pix_data <= d[k+1];
      @(negedge pix_clk);
      if (k >= 1) begin
        to_a = !dual || (1'(k) ^ swap);
        `CHECK_EQ(to_a ? port_a : port_b, d[k]);
      end
    end
    `CHECK_EQ(port_b_oe_n, !dual);
    $display("test pixel dual=%0d swap=%0d done", dual, swap);
  endtask : pix_line

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    mclk = 0;
    pix_clk = 0;
    resetn = 0;
    line_sync = 0;
    pix_data = seed[7:0];
    sel_pins = 0;
    repeat (10) @(posedge mclk);
    resetn <= 1'b1;
    two_wire_master_i.tick(6);
    cs = '{5'd16, 2'b01, 3'b001};
    `CHECK_EQ(clk_setup, cs);
    `CHECK_EQ(clk_decode, exp_decode(cs));
    read_regs(OFS_CLOCK_SETUP, '{8'h80, 8'h48, {4'h0, DIE_REVISION, 1'b0}, 8'h00}, 4);
    $display("test defaults done");
    // Every drive code once and every band code twice; phase corners at both ends.
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      cs = '{(i == 0) ? 5'd0 : (i == 7) ? 5'd31 : seed[4:0], i[1:0], i[2:0]};
      two_wire_master_i.lag = i[0] ? 12 : 0;
      write_regs(OFS_CLOCK_SETUP, '{{cs.sample_phase, 3'h0},
                 {cs.oscillator_band, cs.filter_drive, 3'h0}, 8'h00, 8'h00}, 2);
      `CHECK_EQ(clk_setup, cs);
      `CHECK_EQ(clk_decode, exp_decode(cs));
    end
    two_wire_master_i.lag = 0;
    $display("test clock fields done");
    // Burst runs past the last register and must pile up at 0E.
    write_regs(OFS_ORDER_REV, '{8'hff, 8'h00, 8'h5a, 8'h00}, 3);
    read_regs(OFS_ORDER_REV, '{{4'h8, DIE_REVISION, 1'b0}, 8'h5a, 8'h5a, 8'h00}, 3);
    $display("test pointer clamp done");
    foreach (d_bad[j]) begin
      send_addr(sel_pins, 1'b0, 1'b1);
      send_byte(d_bad[j], 1'b0);
      two_wire_master_i.tick(6);
      `CHECK_EQ(sda_oe_n, 1'b1);
      send_byte(8'h00, 1'b0);
      two_wire_master_i.stop_cond();
    end
    $display("test pointer refusal done");
    for (int s = 0; s < 4; s++) begin
      sel_pins <= s[1:0];
      two_wire_master_i.tick(6);
      send_addr(s[1:0] ^ 2'h1, 1'b0, 1'b0);
      two_wire_master_i.stop_cond();
      send_addr(s[1:0], 1'b0, 1'b1);
      two_wire_master_i.stop_cond();
    end
    sel_pins <= 2'h0;
    two_wire_master_i.tick(6);
    $display("test address select done");
    pix_line(1'b1, 1'b0);
    pix_line(1'b1, 1'b1);
    pix_line(1'b0, 1'b1);
    give_verdict();
  end

endmodule : tb_two_wire_control_slave
